// ==== verilog/qwr_pkg.sv ====
// shared constants and types of the quad word read and wrap engine
package qwr_pkg;
  // -----------------------------------------------------------
  // command opcodes
  // -----------------------------------------------------------
  localparam logic [7:0] OP_QUAD_READ = 8'heb; // baseline quad read
  localparam logic [7:0] OP_WORD_READ = 8'he7; // word quad read
  localparam logic [7:0] OP_OCTAL_READ = 8'he3; // octal-word quad read
  localparam logic [7:0] OP_SET_WRAP = 8'h77; // set burst with wrap
  // -----------------------------------------------------------
  // phase lengths in serial clocks
  // -----------------------------------------------------------
  localparam logic [3:0] OPCODE_CLOCKS = 4'h8; // one bit per clock
  localparam logic [3:0] ADDR_CLOCKS = 4'h6; // 24 bits, nibble wide
  localparam logic [3:0] MODE_CLOCKS = 4'h2; // 8 mode bits
  localparam logic [3:0] DUMMY_QUAD = 4'h4; // baseline read
  localparam logic [3:0] DUMMY_WORD = 4'h2; // word read
  localparam logic [3:0] DUMMY_OCTAL = 4'h0; // octal-word read
  localparam logic [3:0] WRAP_CLOCKS = 4'h8; // 24 dummy + 8 wrap bits
  // -----------------------------------------------------------
  // field codes and reset values
  // -----------------------------------------------------------
  localparam logic [1:0] SKIP_CODE = 2'h2; // mode bits 5:4 = 10
  localparam logic [2:0] WRAP_RESET = 3'h1; // disable bit set
  localparam logic [5:0] WRAP_MASK_MAX = 6'h3f; // 64-byte section
  localparam logic [1:0] WRAP_SEL_MAX = 2'h3; // largest length code
  localparam logic [7:0] EMPTY_BYTE = 8'hff; // sent on underrun
  // -----------------------------------------------------------
  // sequencer states
  // -----------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_OPCODE = 3'h1,
    ST_ADDR = 3'h2,
    ST_MODE = 3'h3,
    ST_DUMMY = 3'h4,
    ST_DATA = 3'h5,
    ST_WRAP = 3'h6,
    ST_IGNORE = 3'h7
  } qwr_state_type;
endpackage

// ==== verilog/qwr_read_engine.sv ====
// serial quad read sequencer with continuous read and burst wrap
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - word read has two dummy clocks
// - quad reads need quad enable set; a frame that skips the opcode reads without checking it
// - eight mode bits follow address, low nibble ignored
// - mode bits 5:4 = 10 skip next opcode
// - other mode values require full opcode next
// - octal read sends data right after mode
// - wrap byte bits 7 and 3:0 ignored
// - wrap bit 4 low enables, 6:5 length
// - wrapped read loops inside aligned section
// - wrap setting persists for later reads
// - wrapping disabled at power-on
// - wrap length survives four-wire command mode
// - address and data four bits per clock
// - baseline read four dummies, variants fewer
module qwr_read_engine #(
  parameter int DATA_W = 8,
  parameter int DEPTH = 2
) (
  // system
  input wire logic CLK,
  input wire logic SYS_RST,
  // serial link pins
  input wire logic SPI_CS_N,
  input wire logic SPI_SCLK,
  input wire logic [3:0] SPI_DQ_IN,
  output logic [3:0] SPI_DQ_OUT,
  output logic [3:0] SPI_DQ_OE,
  // configuration
  input wire logic QUAD_IO_ENABLE,
  input wire logic FOUR_WIRE_COMMAND_MODE,
  // memory array read port
  output logic [23:0] MEM_ADDR,
  input wire logic MEM_RD_VALID,
  input wire logic [DATA_W-1:0] MEM_RD_DATA,
  output logic MEM_RD_READY,
  // status
  output logic [2:0] WRAP_SETTING_BITS,
  output logic CONT_READ_ARMED
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W:0] FULL_COUNT = (PTR_W+1)'(DEPTH);

  // -----------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------
  logic cs_meta_reg, cs_sync_reg, cs_prev_reg; // chip select stages
  logic sclk_meta_reg, sclk_sync_reg, sclk_prev_reg; // clock stages
  logic [3:0] dq_meta_reg, dq_sync_reg; // data line stages

  // two flops per pin, a third on select and clock for edge finding
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      cs_prev_reg <= 1'b1;
      sclk_meta_reg <= 1'b0;
      sclk_sync_reg <= 1'b0;
      sclk_prev_reg <= 1'b0;
      dq_meta_reg <= 4'h0;
      dq_sync_reg <= 4'h0;
    end else begin
      cs_meta_reg <= SPI_CS_N;
      cs_sync_reg <= cs_meta_reg;
      cs_prev_reg <= cs_sync_reg;
      sclk_meta_reg <= SPI_SCLK;
      sclk_sync_reg <= sclk_meta_reg;
      sclk_prev_reg <= sclk_sync_reg;
      dq_meta_reg <= SPI_DQ_IN;
      dq_sync_reg <= dq_meta_reg;
    end
  end

  wire cs_active = ~cs_sync_reg; // frame open
  wire cs_start = ~cs_sync_reg & cs_prev_reg; // frame opening edge
  wire sclk_rise = sclk_sync_reg & ~sclk_prev_reg; // host sample edge
  wire sclk_fall = ~sclk_sync_reg & sclk_prev_reg; // device drive edge

  // -----------------------------------------------------------
  // sequencer registers
  // -----------------------------------------------------------
  qwr_pkg::qwr_state_type state_reg, state_next; // phase
  logic [3:0] cnt_reg, cnt_next; // clocks within a phase
  logic [7:0] cmd_reg, cmd_next; // latched opcode
  logic [23:0] shift_reg, shift_next; // address / wrap shifter
  logic skip_reg, skip_next; // next frame omits opcode
  logic [2:0] wrap_reg, wrap_next; // stored wrap setting
  logic start_fetch; // address complete this edge

  // -----------------------------------------------------------
  // command decode
  // -----------------------------------------------------------
  wire [23:0] shift_in = {shift_reg[19:0], dq_sync_reg};
  wire is_read = (cmd_next == qwr_pkg::OP_QUAD_READ) |
                 (cmd_next == qwr_pkg::OP_WORD_READ) |
                 (cmd_next == qwr_pkg::OP_OCTAL_READ);
  wire read_ok = is_read & QUAD_IO_ENABLE;
  wire wrap_ok = (cmd_next == qwr_pkg::OP_SET_WRAP) & QUAD_IO_ENABLE;
  wire [3:0] dummy_clocks =
    (cmd_reg == qwr_pkg::OP_WORD_READ) ? qwr_pkg::DUMMY_WORD :
    (cmd_reg == qwr_pkg::OP_OCTAL_READ) ? qwr_pkg::DUMMY_OCTAL :
    qwr_pkg::DUMMY_QUAD;
  wire last_clk_opc = (cnt_reg == qwr_pkg::OPCODE_CLOCKS - 4'h1);
  wire last_clk_addr = (cnt_reg == qwr_pkg::ADDR_CLOCKS - 4'h1);
  wire last_clk_mode = (cnt_reg == qwr_pkg::MODE_CLOCKS - 4'h1);
  wire last_clk_wrap = (cnt_reg == qwr_pkg::WRAP_CLOCKS - 4'h1);
  wire last_clk_dummy = (cnt_reg == dummy_clocks - 4'h1);

  // next phase, counters and captured fields
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    cmd_next = cmd_reg;
    shift_next = shift_reg;
    skip_next = skip_reg;
    wrap_next = wrap_reg;
    start_fetch = 1'b0;
    if (!cs_active) begin
      // frame closed
      state_next = qwr_pkg::ST_IDLE;
      cnt_next = 4'h0;
    end else if (cs_start) begin
      // decision from the last mode phase is used once
      cnt_next = 4'h0;
      skip_next = 1'b0;
      if (FOUR_WIRE_COMMAND_MODE) begin
        state_next = qwr_pkg::ST_IGNORE;
      end else if (skip_reg) begin
        state_next = qwr_pkg::ST_ADDR;
      end else begin
        state_next = qwr_pkg::ST_OPCODE;
      end
    end else if (sclk_rise) begin
      cnt_next = cnt_reg + 4'h1;
      unique case (state_reg)
        qwr_pkg::ST_OPCODE: begin
          // opcode one bit per clock on line zero
          cmd_next = {cmd_reg[6:0], dq_sync_reg[0]};
          if (last_clk_opc) begin
            cnt_next = 4'h0;
            if (read_ok) begin
              state_next = qwr_pkg::ST_ADDR;
            end else if (wrap_ok) begin
              state_next = qwr_pkg::ST_WRAP;
            end else begin
              state_next = qwr_pkg::ST_IGNORE;
            end
          end
        end
        qwr_pkg::ST_ADDR: begin
          shift_next = shift_in;
          if (last_clk_addr) begin
            cnt_next = 4'h0;
            start_fetch = 1'b1;
            state_next = qwr_pkg::ST_MODE;
          end
        end
        qwr_pkg::ST_MODE: begin
          // first mode clock carries bits 7:4, second is ignored
          if (cnt_reg == 4'h0) begin
            skip_next = (dq_sync_reg[1:0] == qwr_pkg::SKIP_CODE);
          end
          if (last_clk_mode) begin
            cnt_next = 4'h0;
            if (dummy_clocks == 4'h0) begin
              state_next = qwr_pkg::ST_DATA;
            end else begin
              state_next = qwr_pkg::ST_DUMMY;
            end
          end
        end
        qwr_pkg::ST_DUMMY: begin
          if (last_clk_dummy) begin
            cnt_next = 4'h0;
            state_next = qwr_pkg::ST_DATA;
          end
        end
        qwr_pkg::ST_WRAP: begin
          shift_next = shift_in;
          if (last_clk_wrap) begin
            // upper wrap nibble arrived one clock earlier
            wrap_next = shift_reg[2:0];
            state_next = qwr_pkg::ST_IGNORE;
          end
        end
        qwr_pkg::ST_IDLE, qwr_pkg::ST_DATA, qwr_pkg::ST_IGNORE: begin
          cnt_next = cnt_reg;
        end
      endcase
    end
  end

  // sequencer state update
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg <= qwr_pkg::ST_IDLE;
      cnt_reg <= 4'h0;
      cmd_reg <= 8'h00;
      shift_reg <= 24'h000000;
      skip_reg <= 1'b0;
      wrap_reg <= qwr_pkg::WRAP_RESET;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      cmd_reg <= cmd_next;
      shift_reg <= shift_next;
      skip_reg <= skip_next;
      wrap_reg <= wrap_next;
    end
  end

  // -----------------------------------------------------------
  // address generation with wrap
  // -----------------------------------------------------------
  logic [23:0] fetch_addr_reg; // address being fetched
  logic fetch_en_reg; // fetching allowed this frame
  wire wrap_active = ~wrap_reg[0] &
                     (cmd_reg != qwr_pkg::OP_OCTAL_READ);
  wire [1:0] wrap_shift = qwr_pkg::WRAP_SEL_MAX - wrap_reg[2:1];
  wire [5:0] wrap_mask = qwr_pkg::WRAP_MASK_MAX >> wrap_shift;
  wire [23:0] addr_inc = fetch_addr_reg + 24'h000001;
  wire [23:0] addr_next = wrap_active ?
    {fetch_addr_reg[23:6],
     (fetch_addr_reg[5:0] & ~wrap_mask) | (addr_inc[5:0] & wrap_mask)} :
    addr_inc;

  // -----------------------------------------------------------
  // two-entry read buffer
  // -----------------------------------------------------------
  logic [DATA_W-1:0] buf_mem [0:DEPTH-1]; // entries
  logic [PTR_W-1:0] wr_ptr_reg, rd_ptr_reg; // pointers
  logic [PTR_W:0] count_reg; // occupancy
  logic nib_sel_reg; // low nibble pending
  wire buf_full = (count_reg == FULL_COUNT);
  wire buf_empty = (count_reg == '0);
  wire buf_push = MEM_RD_VALID & MEM_RD_READY;
  wire need_byte = (state_reg == qwr_pkg::ST_DATA) & sclk_fall & ~nib_sel_reg;
  wire buf_pop = need_byte & ~buf_empty;
  wire [PTR_W-1:0] wr_ptr_inc = (wr_ptr_reg == PTR_W'(DEPTH - 1)) ?
    '0 : wr_ptr_reg + 1'b1;
  wire [PTR_W-1:0] rd_ptr_inc = (rd_ptr_reg == PTR_W'(DEPTH - 1)) ?
    '0 : rd_ptr_reg + 1'b1;
  wire [DATA_W-1:0] head_byte = buf_empty ?
    DATA_W'(qwr_pkg::EMPTY_BYTE) : buf_mem[rd_ptr_reg];

  assign MEM_RD_READY = fetch_en_reg & cs_active & ~buf_full; // stalls fetch
  assign MEM_ADDR = fetch_addr_reg;

  // fetch address and enable, enable cleared at frame end
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      fetch_addr_reg <= 24'h000000;
      fetch_en_reg <= 1'b0;
    end else if (!cs_active) begin
      fetch_en_reg <= 1'b0;
    end else if (start_fetch) begin
      fetch_addr_reg <= shift_in;
      fetch_en_reg <= 1'b1;
    end else if (buf_push) begin
      fetch_addr_reg <= addr_next;
    end
  end

  // buffer pointers, flushed at frame end
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (!cs_active) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (buf_push) begin
        wr_ptr_reg <= wr_ptr_inc;
      end
      if (buf_pop) begin
        rd_ptr_reg <= rd_ptr_inc;
      end
      if (buf_push & ~buf_pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (buf_pop & ~buf_push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  // buffer storage, no reset needed
  always_ff @(posedge CLK) begin
    if (buf_push) begin
      buf_mem[wr_ptr_reg] <= MEM_RD_DATA;
    end
  end

  // -----------------------------------------------------------
  // data output shifter
  // -----------------------------------------------------------
  logic [3:0] low_nib_reg; // held low nibble
  logic [3:0] dq_out_reg; // line values
  logic dq_oe_reg; // lines driven

  // drive on falling edges, high nibble first
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      nib_sel_reg <= 1'b0;
      low_nib_reg <= 4'h0;
      dq_out_reg <= 4'h0;
      dq_oe_reg <= 1'b0;
    end else if (!cs_active) begin
      nib_sel_reg <= 1'b0;
      dq_oe_reg <= 1'b0;
    end else if ((state_reg == qwr_pkg::ST_DATA) && sclk_fall) begin
      dq_oe_reg <= 1'b1;
      if (!nib_sel_reg) begin
        dq_out_reg <= head_byte[7:4];
        low_nib_reg <= head_byte[3:0];
        nib_sel_reg <= 1'b1;
      end else begin
        dq_out_reg <= low_nib_reg;
        nib_sel_reg <= 1'b0;
      end
    end
  end

  assign SPI_DQ_OUT = dq_out_reg;
  assign SPI_DQ_OE = {4{dq_oe_reg}};
  assign WRAP_SETTING_BITS = wrap_reg;
  assign CONT_READ_ARMED = skip_reg;
endmodule
`default_nettype wire

// ==== testbench/qwr_read_engine_assertions.sv ====
// pin-level assertion checker for the quad read engine
`timescale 1ns/10ps
`default_nettype none
module qwr_read_engine_assertions #(
  parameter int DATA_W = 8,
  parameter int DEPTH = 2
) (
  // system
  input wire logic CLK,
  input wire logic SYS_RST,
  // link
  input wire logic SPI_CS_N,
  input wire logic SPI_SCLK,
  input wire logic [3:0] SPI_DQ_OUT,
  input wire logic [3:0] SPI_DQ_OE,
  // config and status
  input wire logic QUAD_IO_ENABLE,
  input wire logic FOUR_WIRE_COMMAND_MODE,
  input wire logic [2:0] WRAP_SETTING_BITS,
  input wire logic CONT_READ_ARMED,
  // memory port
  input wire logic [23:0] MEM_ADDR,
  input wire logic MEM_RD_VALID,
  input wire logic MEM_RD_READY
);
  // ------------------------------------------
  // idle tracking
  // ------------------------------------------
  logic [2:0] idle_reg; // chip select high cycles, saturating
  logic [2:0] idle_next;
  logic lock_reg; // frame now starting must be refused
  logic lock_next;
  wire logic quiet = idle_reg > 3'h4; // device settled after frame
  assign idle_next = SPI_CS_N ? idle_reg + {2'h0, idle_reg != 3'h7} : 3'h0;
  assign lock_next = quiet ? (!QUAD_IO_ENABLE || FOUR_WIRE_COMMAND_MODE)
    && !CONT_READ_ARMED : lock_reg;
  // counters update
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      idle_reg <= 3'h0;
      lock_reg <= 1'b0;
    end else begin
      idle_reg <= idle_next;
      lock_reg <= lock_next;
    end
  end
  // ------------------------------------------
  // properties
  // ------------------------------------------
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence accept_s;
    (SPI_DQ_OE == 4'hf) && MEM_RD_VALID && MEM_RD_READY;
  endsequence
  oe_uniform_a: assert property ($rose(SPI_DQ_OE[0]) |->
    !SPI_CS_N && (SPI_DQ_OE == 4'hf))
    else $error("oe lanes differ");
  oe_idle_off_a: assert property (quiet |-> SPI_DQ_OE == 4'h0)
    else $error("drive after frame");
  refuse_silent_a: assert property (lock_reg |-> SPI_DQ_OE == 4'h0)
    else $error("refused frame drives");
  refuse_keep_a: assert property (lock_reg |=>
    $stable(WRAP_SETTING_BITS))
    else $error("wrap bits moved");
  wrap_idle_a: assert property (quiet |-> $stable(WRAP_SETTING_BITS))
    else $error("wrap bits moved idle");
  armed_idle_a: assert property (quiet |-> $stable(CONT_READ_ARMED))
    else $error("armed moved idle");
  addr_hold_a: assert property ((SPI_DQ_OE == 4'hf) &&
    !(MEM_RD_VALID && MEM_RD_READY) |=> $stable(MEM_ADDR))
    else $error("address moved");
  addr_step_a: assert property (accept_s ##0
    WRAP_SETTING_BITS[0] |=> MEM_ADDR == $past(MEM_ADDR) + 24'h1)
    else $error("address step");
  dq_on_fall_a: assert property ($changed(SPI_DQ_OUT) |-> !SPI_SCLK)
    else $error("data moved while clock high");
endmodule
bind qwr_read_engine qwr_read_engine_assertions #(.DATA_W(DATA_W),
  .DEPTH(DEPTH)) u_chk (.CLK(CLK), .SYS_RST(SYS_RST), .SPI_CS_N(SPI_CS_N),
  .SPI_SCLK(SPI_SCLK), .SPI_DQ_OUT(SPI_DQ_OUT), .SPI_DQ_OE(SPI_DQ_OE),
  .QUAD_IO_ENABLE(QUAD_IO_ENABLE), .MEM_ADDR(MEM_ADDR),
  .FOUR_WIRE_COMMAND_MODE(FOUR_WIRE_COMMAND_MODE),
  .WRAP_SETTING_BITS(WRAP_SETTING_BITS), .CONT_READ_ARMED(CONT_READ_ARMED),
  .MEM_RD_VALID(MEM_RD_VALID), .MEM_RD_READY(MEM_RD_READY));
`default_nettype wire

// ==== testbench/qwr_host_model.sv ====
// host controller model driving the serial link
`timescale 1ns/10ps
`default_nettype none
module qwr_host_model (
  // link pins toward the device
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic [3:0] spi_dq,
  // device drivers
  input wire logic [3:0] dev_dq,
  input wire logic [3:0] dev_oe
);
  logic [3:0] host_dq = 4'h0; // nibble the host drives
  logic host_oe = 1'b0; // host drives the lines
  logic [3:0] last_dq = 4'h0; // level at last rise
  logic [3:0] samp; // nibble taken at a rise
  logic [7:0] got[$]; // bytes read back
  // floating lines show the inverse of their last level
  assign spi_dq = host_oe ? host_dq : dev_oe[0] ? dev_dq : ~last_dq;
  // link idle: select high, clock low
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
  end
  always @(posedge spi_sclk) last_dq <= spi_dq;
  // one link clock: drive while low, sample at rise
  task automatic tick(input logic [3:0] nib, input bit drv, input bit rel);
    spi_sclk = 1'b0;
    host_oe = drv;
    host_dq = nib;
    #62.5 spi_sclk = 1'b1;
    samp = spi_dq;
    #30 if (rel) host_oe = 1'b0;
    #32.5;
  endtask
  // frame: nibbles driven, then n bytes read high nibble first
  task automatic frame(input logic [3:0] pre[$], input int n);
    logic [3:0] hi;
    got.delete();
    spi_cs_n = 1'b0;
    #62.5;
    foreach (pre[i]) tick(pre[i], 1'b1, n > 0 && i == pre.size() - 1);
    repeat (n) begin
      tick(4'h0, 1'b0, 1'b0);
      hi = samp;
      tick(4'h0, 1'b0, 1'b0);
      got.push_back({hi, samp});
    end
    spi_sclk = 1'b0;
    #62.5 spi_cs_n = 1'b1;
    #250;
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// self-checking bench for the quad read engine
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  typedef logic [3:0] qwr_nib_type[$]; // link nibbles of a frame
  logic clk = 1'b0, rst = 1'b1, qe = 1'b1, four_wire = 1'b0;
  logic mem_valid = 1'b0, ready, armed, cs_n, sclk;
  logic [3:0] dq_in, dq_out, dq_oe;
  logic [23:0] mem_addr;
  logic [2:0] wrap_bits, cur_w = 3'h1; // expected wrap state
  int failures = 0, checks_done = 0, cyc = 0, oe_cycles = 0;
  wire logic [7:0] mem_data = mem_addr[7:0] + 8'h31; // array contents
  qwr_read_engine #(.DATA_W(8), .DEPTH(2)) uut (
    .CLK(clk), .SYS_RST(rst), .SPI_CS_N(cs_n), .SPI_SCLK(sclk),
    .SPI_DQ_IN(dq_in), .SPI_DQ_OUT(dq_out), .SPI_DQ_OE(dq_oe),
    .QUAD_IO_ENABLE(qe), .FOUR_WIRE_COMMAND_MODE(four_wire),
    .MEM_ADDR(mem_addr), .MEM_RD_VALID(mem_valid), .MEM_RD_DATA(mem_data),
    .MEM_RD_READY(ready), .WRAP_SETTING_BITS(wrap_bits),
    .CONT_READ_ARMED(armed));
  qwr_host_model host (.spi_cs_n(cs_n), .spi_sclk(sclk), .spi_dq(dq_in),
    .dev_dq(dq_out), .dev_oe(dq_oe));
  initial forever #5 clk = ~clk;
  // source stalls every other cycle; driven-cycle count; hang guard
  always @(posedge clk) begin
    mem_valid <= #1 ~mem_valid;
    if (dq_oe != 4'h0) oe_cycles++;
    cyc++;
    if (cyc == 40000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] g, input logic [23:0] e, string w);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t %s got %h want %h", $time, w, g, e);
    end
  endtask
  // next expected address, wrapping inside the section when enabled
  function automatic logic [23:0] nxt(input logic [23:0] a, input bit wr);
    logic [23:0] m;
    m = (24'h8 << cur_w[2:1]) - 24'h1;
    if (wr && !cur_w[0]) return (a & ~m) | ((a + 24'h1) & m);
    return a + 24'h1;
  endfunction
  function automatic qwr_nib_type build(input bit op_on,
      input logic [7:0] op, input logic [23:0] a, input logic [7:0] mode,
      input int dum);
    qwr_nib_type q;
    if (op_on) for (int i = 7; i >= 0; i--) q.push_back({3'h0, op[i]});
    for (int i = 5; i >= 0; i--) q.push_back(a[i*4 +: 4]);
    q.push_back(mode[7:4]);
    q.push_back(mode[3:0]);
    repeat (dum) q.push_back(4'h0);
    return q;
  endfunction
  task automatic rd(input bit op_on, input logic [7:0] op,
      input logic [23:0] a, input logic [7:0] mode, input int dum, int n);
    logic [23:0] e;
    e = a;
    host.frame(build(op_on, op, a, mode, dum), n);
    chk(24'(host.got.size()), 24'(n), "count");
    foreach (host.got[i]) begin
      chk(24'(host.got[i]), 24'(8'(e[7:0] + 8'h31)), "data");
      e = nxt(e, op != qwr_pkg::OP_OCTAL_READ);
    end
  endtask
  task automatic set_wrap(input logic [7:0] b, input logic [2:0] want);
    host.frame(build(1'b1, qwr_pkg::OP_SET_WRAP, 24'h0, b, 0), 0);
    chk(24'(wrap_bits), 24'(want), "wrap bits");
    cur_w = want;
  endtask
  task automatic cfg(input bit q, input bit f);
    @(posedge clk);
    #1 qe = q;
    four_wire = f;
  endtask
  task automatic t_power_on();
    chk(24'(wrap_bits), 24'h1, "wrap reset");
    chk(24'(armed), 24'h0, "armed reset");
    set_wrap(8'h10, 3'h1);
    rd(1'b1, qwr_pkg::OP_WORD_READ, 24'h0001fc, 8'h00, 2, 6);
    chk(24'(armed), 24'h0, "armed");
  endtask
  task automatic t_wrap_modes();
    logic [23:0] len;
    for (int s = 0; s < 4; s++) begin
      len = 24'h8 << s;
      set_wrap({1'b1, 2'(s), 1'b0, 4'ha}, {2'(s), 1'b0});
      rd(1'b1, s[0] ? qwr_pkg::OP_QUAD_READ : qwr_pkg::OP_WORD_READ,
        24'h300 + len - 24'h2, 8'h00, s[0] ? 4 : 2, int'(len) + 2);
    end
    rd(1'b1, qwr_pkg::OP_OCTAL_READ, 24'h000230, 8'h00, 0, 20);
  endtask
  task automatic t_cont_read();
    rd(1'b1, qwr_pkg::OP_WORD_READ, 24'h000410, 8'h2f, 2, 2);
    chk(24'(armed), 24'h1, "armed");
    rd(1'b0, qwr_pkg::OP_WORD_READ, 24'h000420, 8'hd0, 2, 2);
    chk(24'(armed), 24'h0, "armed");
    rd(1'b1, qwr_pkg::OP_WORD_READ, 24'h000430, 8'h20, 2, 2);
    host.frame(build(1'b0, 8'h00, 24'hffffff, 8'hff, 0), 0);
    chk(24'(armed), 24'h0, "armed");
    rd(1'b1, qwr_pkg::OP_WORD_READ, 24'h000440, 8'h00, 2, 2);
  endtask
  task automatic t_refuse();
    qwr_nib_type q;
    int oe_base;
    cfg(1'b0, 1'b0);
    oe_base = oe_cycles;
    host.frame(build(1'b1, qwr_pkg::OP_WORD_READ, 24'h500, 8'h00, 2), 2);
    set_wrap(8'h10, cur_w);
    cfg(1'b1, 1'b1);
    host.frame(build(1'b1, qwr_pkg::OP_OCTAL_READ, 24'h500, 8'h00, 0), 2);
    set_wrap(8'h10, cur_w);
    chk(24'(oe_cycles - oe_base), 24'h0, "refused drive");
    cfg(1'b1, 1'b0);
    q = build(1'b1, qwr_pkg::OP_SET_WRAP, 24'h0, 8'h10, 0);
    q.pop_back();
    host.frame(q, 0);
    chk(24'(wrap_bits), 24'(cur_w), "short wrap");
    set_wrap(8'h90, 3'h1);
    rd(1'b1, qwr_pkg::OP_WORD_READ, 24'h0006fc, 8'h00, 2, 8);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    repeat (5) @(posedge clk);
    t_power_on();
    t_wrap_modes();
    t_cont_read();
    t_refuse();
    give_verdict();
  end
endmodule
`default_nettype wire
